// >>> core/bsc_test_port.sv
// Boundary scan test port: TAP, data registers and pin muxing
//
// Summary of operation
// [R1] Low test reset returns the TAP controller to reset at once, at any time.
// [R2] Every digital pin and analog/digital internal boundary carries a scan cell.
// [R3] All cells form one shift chain that drives or captures pin levels.
// [R4] Any number of vectors shift in on TDI and are applied internally.
// [R5] Captured results shift out serially on TDO for external checking.
// [R6] An identification register holds revision, part number and maker fields.
// [R7] Identification is read only via the TAP after loading its instruction.
// [R8] Exactly four instructions decode: sample/preload, extest, ID code, bypass.
// [R9] Instructions are selected by the standard TMS-driven state machine.
// [R10] Control cell 25 at zero floats its three-state outputs during extest.
// [R11] Cell 25 governs flag outputs at cells 26,27,30,31,32,34,35,37.
// [R12] Input pins observed at cells 28,29,33,36,38,39.
// [R13] Cells 10-24 are converter interface cells safe at zero; 0,2-9 internal.
// [R14] Cell 1 is a control cell with safe value one.
// [R15] Cell 1 at one floats pixel port A; each pin has output and input cells.
// [R16] Serial data output cell 58 controls itself; cell 59 observes the pin.
// [R17] Part number is shared by all variants; revision sits in top four bits.
// [R18] Bypass inserts one bit between TDI and TDO, capturing zero.
// [R19] Test reset loads the identification instruction.
`default_nettype none

module bsc_test_port (
	input  wire logic                         sys_clk,
	input  wire logic                         reset_n,
	input  wire logic                         tck,
	input  wire logic                         trst_n,
	input  wire logic                         tms,
	input  wire logic                         tdi,
	output logic                              tdo,
	output logic                              tdo_oe,
	input  wire bsc_pkg::bsc_flag_pins_type   core_flags,
	input  wire logic                         core_flags_oe,
	output bsc_pkg::bsc_flag_pins_type        flag_pins,
	output logic                              flag_pins_oe,
	input  wire bsc_pkg::bsc_input_pins_type  input_pins,
	output bsc_pkg::bsc_input_pins_type       core_input_pins,
	input  wire logic [7:0]                   core_port_a_out,
	input  wire logic                         core_port_a_oe,
	input  wire logic [7:0]                   pixel_port_a_in,
	output logic      [7:0]                   pixel_port_a_out,
	output logic                              pixel_port_a_oe,
	output logic      [7:0]                   core_port_a_in,
	input  wire logic                         core_sda_low,
	input  wire logic                         sda_in,
	output logic                              sda_out,
	output logic                              sda_oe,
	output logic                              core_sda_in,
	input  wire logic [8:0]                   core_analog_ctrl,
	output logic      [8:0]                   analog_ctrl,
	input  wire logic [14:0]                  adc_data,
	output logic      [14:0]                  core_adc_data,
	input  wire logic [21:0]                  misc_observe,
	output logic      [21:0]                  misc_drive,
	output logic                              extest_active
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	bsc_pkg::bsc_tap_ctl_type ctl;
	logic [3:0]                ir;
	logic [3:0]                ir_shift;
	logic                      extest_mode;
	logic                      sel_bsr;
	logic                      sel_id;
	logic                      bypass_bit;
	logic [31:0]               id_shift;
	logic [79:0]               bsr_shift;
	logic [79:0]               bsr_update;
	logic [79:0]               observe_tck;
	logic                      next_tdo;

	logic [79:0]               observe;
	logic [79:0]               observe_q;
	logic [79:0]               upd_sys;
	logic                      extest_sys;
	logic [14:0]               pins_sync;
	logic [5:0]                inputs_sync;
	logic [7:0]                port_a_sync;
	logic                      sda_sync;
	logic [7:0]                drive_flags;
	logic [7:0]                drive_port_a;
	logic [8:0]                drive_int;
	logic [14:0]               drive_adc;
	logic [21:0]               drive_misc;

	// ------------------------------------------------------------
	// Test clock domain: controller and instruction
	// ------------------------------------------------------------
	bsc_tap_ctrl u_tap (
		.tck    (tck),
		.trst_n (trst_n),
		.tms    (tms),
		.ctl    (ctl)
	);

	// Mode flag loads with the instruction: tck may stop right after update
	// [R19] Reset loads ID code
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir          <= bsc_pkg::IR_RESET;
			extest_mode <= 1'b0;
		end else if (ctl.logic_reset) begin
			ir          <= bsc_pkg::IR_RESET;
			extest_mode <= 1'b0;
		end else if (ctl.update_ir) begin
			ir          <= ir_shift;
			extest_mode <= (ir_shift == bsc_pkg::IR_EXTEST);
		end
	end

	// [R9] Instruction shift path
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_shift <= bsc_pkg::IR_CAPTURE;
		end else if (ctl.capture_ir) begin
			ir_shift <= bsc_pkg::IR_CAPTURE;
		end else if (ctl.shift_ir) begin
			ir_shift <= {tdi, ir_shift[3:1]};
		end
	end

	// [R8] Four instructions, rest bypass
	always_comb begin
		sel_bsr = (ir == bsc_pkg::IR_EXTEST) || (ir == bsc_pkg::IR_SAMPLE);
		sel_id  = (ir == bsc_pkg::IR_IDCODE);
	end

	// ------------------------------------------------------------
	// Test clock domain: data registers
	// ------------------------------------------------------------
	// [R18] Bypass captures zero
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			bypass_bit <= 1'b0;
		end else if (ctl.capture_dr) begin
			bypass_bit <= 1'b0;
		end else if (ctl.shift_dr) begin
			bypass_bit <= tdi;
		end
	end

	// [R6] [R7] [R17] ID only under its instruction
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			id_shift <= bsc_pkg::ID_VALUE;
		end else if (ctl.capture_dr && sel_id) begin
			id_shift <= bsc_pkg::ID_VALUE;
		end else if (ctl.shift_dr && sel_id) begin
			id_shift <= {tdi, id_shift[31:1]};
		end
	end

	// [R3] [R4] Boundary chain, cell 0 nearest TDO
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			bsr_shift <= bsc_pkg::BSR_SAFE;
		end else if (ctl.capture_dr && sel_bsr) begin
			bsr_shift <= observe_tck;
		end else if (ctl.shift_dr && sel_bsr) begin
			bsr_shift <= {tdi, bsr_shift[79:1]};
		end
	end

	// [R4] Update stage holds applied vector
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			bsr_update <= bsc_pkg::BSR_SAFE;
		end else if (ctl.update_dr && sel_bsr) begin
			bsr_update <= bsr_shift;
		end
	end

	// [R5] Serial output path
	always_comb begin
		if (ctl.shift_ir) begin
			next_tdo = ir_shift[0];
		end else if (sel_bsr) begin
			next_tdo = bsr_shift[0];
		end else if (sel_id) begin
			next_tdo = id_shift[0];
		end else begin
			next_tdo = bypass_bit;
		end
	end

	// Falling edge so the tester samples a settled bit on the next rise
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo    <= next_tdo;
			tdo_oe <= ctl.shift_dr || ctl.shift_ir;
		end
	end

	// ------------------------------------------------------------
	// Crossings
	// ------------------------------------------------------------
	// Cells are independent static levels, so per-bit syncs suffice
	bsc_sync #(
		.WIDTH (81),
		.AGREE (1'b0)
	) u_upd_sync (
		.clk     (sys_clk),
		.reset_n (reset_n),
		.d       ({extest_mode, bsr_update}),
		.q       ({extest_sys, upd_sys})
	);

	bsc_sync #(
		.WIDTH (bsc_pkg::BSR_LEN),
		.AGREE (1'b0)
	) u_obs_sync (
		.clk     (tck),
		.reset_n (trst_n),
		.d       (observe_q),
		.q       (observe_tck)
	);

	bsc_sync #(
		.WIDTH (bsc_pkg::N_PIN_SYNC),
		.AGREE (1'b1)
	) u_pin_sync (
		.clk     (sys_clk),
		.reset_n (reset_n),
		.d       ({input_pins, pixel_port_a_in, sda_in}),
		.q       (pins_sync)
	);

	assign inputs_sync = pins_sync[14:9];
	assign port_a_sync = pins_sync[8:1];
	assign sda_sync    = pins_sync[0];

	// ------------------------------------------------------------
	// System domain: observed levels
	// ------------------------------------------------------------
	// [R2] Every pin and interface observed
	always_comb begin
		observe = '0;
		// [R11] Flag outputs and control
		for (int i = 0; i < bsc_pkg::N_FLAGS; i++) begin
			observe[bsc_pkg::FLAG_POS[i]] = core_flags[i];
		end
		observe[bsc_pkg::POS_FLAG_CTL] = core_flags_oe;
		// [R12] Input observe cells
		for (int i = 0; i < bsc_pkg::N_INPUTS; i++) begin
			observe[bsc_pkg::INPUT_POS[i]] = inputs_sync[i];
		end
		// [R13] Internal and converter cells
		observe[bsc_pkg::POS_INT0] = core_analog_ctrl[0];
		for (int i = 1; i < bsc_pkg::N_INT; i++) begin
			observe[bsc_pkg::POS_INT_LO + i - 1] = core_analog_ctrl[i];
		end
		for (int i = 0; i < bsc_pkg::N_ADC; i++) begin
			observe[bsc_pkg::POS_ADC_LO + i] = adc_data[i];
		end
		// [R15] Port A output and input cells
		observe[bsc_pkg::POS_PORT_A_CTL] = ~core_port_a_oe;
		for (int i = 0; i < bsc_pkg::N_PORT_A; i++) begin
			observe[bsc_pkg::POS_PORT_A_OUT + 2 * i]     = core_port_a_out[i];
			observe[bsc_pkg::POS_PORT_A_OUT + 2 * i + 1] = port_a_sync[i];
		end
		// [R16] Serial data cells
		observe[bsc_pkg::POS_SDA_OUT] = ~core_sda_low;
		observe[bsc_pkg::POS_SDA_IN]  = sda_sync;
		for (int i = 0; i < bsc_pkg::N_MISC_LO; i++) begin
			observe[bsc_pkg::POS_MISC_LO + i] = misc_observe[i];
		end
		observe[bsc_pkg::POS_MISC_MID] = misc_observe[bsc_pkg::N_MISC_LO];
		for (int i = 0; i < bsc_pkg::N_MISC_HI; i++) begin
			observe[bsc_pkg::POS_MISC_HI + i] = misc_observe[bsc_pkg::N_MISC_LO + 1 + i];
		end
	end

	// Snapshot gives the crossing a clean flop source
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			observe_q <= '0;
		end else begin
			observe_q <= observe;
		end
	end

	// ------------------------------------------------------------
	// System domain: applied levels
	// ------------------------------------------------------------
	always_comb begin
		drive_flags  = '0;
		drive_port_a = '0;
		drive_int    = '0;
		drive_adc    = '0;
		drive_misc   = '0;
		for (int i = 0; i < bsc_pkg::N_FLAGS; i++) begin
			drive_flags[i] = upd_sys[bsc_pkg::FLAG_POS[i]];
		end
		for (int i = 0; i < bsc_pkg::N_PORT_A; i++) begin
			drive_port_a[i] = upd_sys[bsc_pkg::POS_PORT_A_OUT + 2 * i];
		end
		drive_int[0] = upd_sys[bsc_pkg::POS_INT0];
		for (int i = 1; i < bsc_pkg::N_INT; i++) begin
			drive_int[i] = upd_sys[bsc_pkg::POS_INT_LO + i - 1];
		end
		for (int i = 0; i < bsc_pkg::N_ADC; i++) begin
			drive_adc[i] = upd_sys[bsc_pkg::POS_ADC_LO + i];
		end
		for (int i = 0; i < bsc_pkg::N_MISC_LO; i++) begin
			drive_misc[i] = upd_sys[bsc_pkg::POS_MISC_LO + i];
		end
		drive_misc[bsc_pkg::N_MISC_LO] = upd_sys[bsc_pkg::POS_MISC_MID];
		for (int i = 0; i < bsc_pkg::N_MISC_HI; i++) begin
			drive_misc[bsc_pkg::N_MISC_LO + 1 + i] = upd_sys[bsc_pkg::POS_MISC_HI + i];
		end
	end

	// [R4] Extest applies vector, else normal path except misc_drive, which takes the chain in both modes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			flag_pins        <= '0;
			flag_pins_oe     <= 1'b0;
			pixel_port_a_out <= '0;
			pixel_port_a_oe  <= 1'b0;
			sda_oe           <= 1'b0;
			analog_ctrl      <= '0;
			core_adc_data    <= '0;
			misc_drive       <= '0;
			extest_active    <= 1'b0;
		end else if (extest_sys) begin
			flag_pins        <= bsc_pkg::bsc_flag_pins_type'(drive_flags);
			// [R10] Cell 25 zero floats flags
			flag_pins_oe     <= upd_sys[bsc_pkg::POS_FLAG_CTL];
			pixel_port_a_out <= drive_port_a;
			// [R14] [R15] Cell 1 one floats port A
			pixel_port_a_oe  <= ~upd_sys[bsc_pkg::POS_PORT_A_CTL];
			// [R16] Released pin pulls weakly high
			sda_oe           <= ~upd_sys[bsc_pkg::POS_SDA_OUT];
			// [R13] Internal interfaces from chain
			analog_ctrl      <= drive_int;
			core_adc_data    <= drive_adc;
			misc_drive       <= drive_misc;
			extest_active    <= 1'b1;
		end else begin
			flag_pins        <= core_flags;
			flag_pins_oe     <= core_flags_oe;
			pixel_port_a_out <= core_port_a_out;
			pixel_port_a_oe  <= core_port_a_oe;
			sda_oe           <= core_sda_low;
			analog_ctrl      <= core_analog_ctrl;
			core_adc_data    <= adc_data;
			misc_drive       <= drive_misc;
			extest_active    <= 1'b0;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;

	assign core_input_pins = bsc_pkg::bsc_input_pins_type'(inputs_sync);
	assign core_port_a_in  = port_a_sync;
	assign core_sda_in     = sda_sync;

endmodule

`default_nettype wire

// >>> pkg/bsc_pkg.sv
// Constants, types and cell map of the boundary scan test port
`default_nettype none

package bsc_pkg;

	// ------------------------------------------------------------
	// Instruction register
	// ------------------------------------------------------------
	localparam int       IR_WIDTH   = 4;
	localparam logic [3:0] IR_EXTEST  = 4'h0;
	localparam logic [3:0] IR_SAMPLE  = 4'h1;
	localparam logic [3:0] IR_IDCODE  = 4'h2;
	localparam logic [3:0] IR_BYPASS  = 4'hf;
	// Fixed 01 in the low bits, as the scan standard asks
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] IR_RESET   = IR_IDCODE;

	// ------------------------------------------------------------
	// Identification register (all field values arbitrary)
	// ------------------------------------------------------------
	localparam int         ID_WIDTH   = 32;
	localparam logic [3:0]  ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART    = 16'h5a3c;
	localparam logic [10:0] ID_MANUF   = 11'h2b4;
	localparam logic [31:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_MANUF, 1'b1};

	// ------------------------------------------------------------
	// Boundary register layout
	// ------------------------------------------------------------
	localparam int BSR_LEN        = 80;
	localparam int POS_INT0       = 0;
	localparam int POS_PORT_A_CTL = 1;
	localparam int POS_INT_LO     = 2;
	localparam int N_INT          = 9;
	localparam int POS_ADC_LO     = 10;
	localparam int N_ADC          = 15;
	localparam int POS_FLAG_CTL   = 25;
	localparam int N_FLAGS        = 8;
	localparam int N_INPUTS       = 6;
	localparam int POS_MISC_LO    = 40;
	localparam int N_MISC_LO      = 18;
	localparam int POS_SDA_OUT    = 58;
	localparam int POS_SDA_IN     = 59;
	localparam int POS_MISC_MID   = 60;
	localparam int POS_PORT_A_OUT = 61;
	localparam int N_PORT_A       = 8;
	localparam int POS_MISC_HI    = 77;
	localparam int N_MISC_HI      = 3;
	localparam int N_MISC         = 22;
	localparam int N_PIN_SYNC     = 15;
	// Flag pin bit i sits at FLAG_POS[i]; bit 0 is the struct's last field
	localparam int FLAG_POS [0:7]  = '{37, 35, 34, 32, 31, 30, 27, 26};
	localparam int INPUT_POS [0:5] = '{39, 38, 36, 33, 29, 28};
	// Control cells park disabled, converter cells at zero
	localparam logic [79:0] BSR_SAFE = 80'h0000_0400_0000_0000_0002;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		st_test_logic_reset, st_run_test_idle,
		st_select_dr, st_capture_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr, st_update_dr,
		st_select_ir, st_capture_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_update_ir
	} bsc_tap_state_type;

	typedef struct packed {
		logic logic_reset;
		logic capture_dr;
		logic shift_dr;
		logic update_dr;
		logic capture_ir;
		logic shift_ir;
		logic update_ir;
	} bsc_tap_ctl_type;

	typedef struct packed {
		logic odd_even_indicator;
		logic vertical_sync_out_n;
		logic horizontal_sync_out_n;
		logic active_window;
		logic pixel_valid_flag;
		logic fifo_almost_full;
		logic fifo_almost_empty;
		logic field_buffer_flag;
	} bsc_flag_pins_type;

	typedef struct packed {
		logic crystal_format_select;
		logic odd_even_sense_enable_n;
		logic fifo_read_enable;
		logic fifo_reset_n;
		logic vertical_sense_enable_n;
		logic pixel_clock_input;
	} bsc_input_pins_type;

endpackage

`default_nettype wire

// >>> core/bsc_sync.sv
// Level synchroniser, two stages or three stages with agreement
`default_nettype none

module bsc_sync #(
	parameter int WIDTH = 1,
	parameter bit AGREE = 1'b0
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= d;
			stage2 <= stage1;
		end
	end

	generate
		if (AGREE) begin : g_agree
			logic [WIDTH-1:0] stage3;
			logic [WIDTH-1:0] held;
			// A bit moves only once stages two and three agree
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					stage3 <= '0;
					held   <= '0;
				end else begin
					stage3 <= stage2;
					held   <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & held);
				end
			end
			assign q = held;
		end else begin : g_plain
			assign q = stage2;
		end
	endgenerate

endmodule

`default_nettype wire

// >>> core/bsc_tap_ctrl.sv
// Test access port state machine
`default_nettype none

module bsc_tap_ctrl (
	input  wire logic             tck,
	input  wire logic             trst_n,
	input  wire logic             tms,
	output bsc_pkg::bsc_tap_ctl_type ctl
);

	bsc_pkg::bsc_tap_state_type state;
	bsc_pkg::bsc_tap_state_type next_state;

	// [R1] Async test reset
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			state <= bsc_pkg::st_test_logic_reset;
		end else begin
			state <= next_state;
		end
	end

	// [R9] Standard state walk
	always_comb begin
		next_state = state;
		case (state)
			bsc_pkg::st_test_logic_reset: next_state = tms ? bsc_pkg::st_test_logic_reset : bsc_pkg::st_run_test_idle;
			bsc_pkg::st_run_test_idle:    next_state = tms ? bsc_pkg::st_select_dr : bsc_pkg::st_run_test_idle;
			bsc_pkg::st_select_dr:        next_state = tms ? bsc_pkg::st_select_ir : bsc_pkg::st_capture_dr;
			bsc_pkg::st_capture_dr:       next_state = tms ? bsc_pkg::st_exit1_dr : bsc_pkg::st_shift_dr;
			bsc_pkg::st_shift_dr:         next_state = tms ? bsc_pkg::st_exit1_dr : bsc_pkg::st_shift_dr;
			bsc_pkg::st_exit1_dr:         next_state = tms ? bsc_pkg::st_update_dr : bsc_pkg::st_pause_dr;
			bsc_pkg::st_pause_dr:         next_state = tms ? bsc_pkg::st_exit2_dr : bsc_pkg::st_pause_dr;
			bsc_pkg::st_exit2_dr:         next_state = tms ? bsc_pkg::st_update_dr : bsc_pkg::st_shift_dr;
			bsc_pkg::st_update_dr:        next_state = tms ? bsc_pkg::st_select_dr : bsc_pkg::st_run_test_idle;
			bsc_pkg::st_select_ir:        next_state = tms ? bsc_pkg::st_test_logic_reset : bsc_pkg::st_capture_ir;
			bsc_pkg::st_capture_ir:       next_state = tms ? bsc_pkg::st_exit1_ir : bsc_pkg::st_shift_ir;
			bsc_pkg::st_shift_ir:         next_state = tms ? bsc_pkg::st_exit1_ir : bsc_pkg::st_shift_ir;
			bsc_pkg::st_exit1_ir:         next_state = tms ? bsc_pkg::st_update_ir : bsc_pkg::st_pause_ir;
			bsc_pkg::st_pause_ir:         next_state = tms ? bsc_pkg::st_exit2_ir : bsc_pkg::st_pause_ir;
			bsc_pkg::st_exit2_ir:         next_state = tms ? bsc_pkg::st_update_ir : bsc_pkg::st_shift_ir;
			bsc_pkg::st_update_ir:        next_state = tms ? bsc_pkg::st_select_dr : bsc_pkg::st_run_test_idle;
			default:                      next_state = bsc_pkg::st_test_logic_reset;
		endcase
	end

	always_comb begin
		ctl.logic_reset = (state == bsc_pkg::st_test_logic_reset);
		ctl.capture_dr  = (state == bsc_pkg::st_capture_dr);
		ctl.shift_dr    = (state == bsc_pkg::st_shift_dr);
		ctl.update_dr   = (state == bsc_pkg::st_update_dr);
		ctl.capture_ir  = (state == bsc_pkg::st_capture_ir);
		ctl.shift_ir    = (state == bsc_pkg::st_shift_ir);
		ctl.update_ir   = (state == bsc_pkg::st_update_ir);
	end

endmodule

`default_nettype wire

// >>> tb/bsc_sva.sv
// Checker of the boundary scan test port
`default_nettype none
module bsc_sva (
	input wire logic                        sys_clk,
	input wire logic                        reset_n,
	input wire logic                        trst_n,
	input wire logic                        tdo,
	input wire logic                        tdo_oe,
	input wire bsc_pkg::bsc_flag_pins_type  core_flags,
	input wire logic                        core_flags_oe,
	input wire bsc_pkg::bsc_flag_pins_type  flag_pins,
	input wire logic                        flag_pins_oe,
	input wire bsc_pkg::bsc_input_pins_type input_pins,
	input wire bsc_pkg::bsc_input_pins_type core_input_pins,
	input wire logic                        core_port_a_oe,
	input wire logic                        pixel_port_a_oe,
	input wire logic                        core_sda_low,
	input wire logic                        sda_out,
	input wire logic                        sda_oe,
	input wire logic                        extest_active
);
	// ----
	// Properties
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Functional mode settled long enough for the pin muxes
	sequence s_func;
		(reset_n && !extest_active) [*3] ##1 !extest_active;
	endsequence
	sequence s_steady;
		(reset_n && $stable(input_pins)) [*6];
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !(flag_pins_oe | pixel_port_a_oe | sda_oe))
		else $error("pins driven in reset");
	a_trst_clears: assert property (!trst_n |-> !tdo_oe && !tdo) else $error("tdo live in test reset");
	a_flags_follow: assert property (s_func |-> flag_pins == $past(core_flags)) else $error("flag values");
	a_flag_oe_follow: assert property (s_func |-> flag_pins_oe == $past(core_flags_oe)) else $error("flag oe");
	a_port_a_follow: assert property (s_func |-> pixel_port_a_oe == $past(core_port_a_oe)) else $error("port oe");
	a_sda_follow: assert property (s_func |-> sda_oe == $past(core_sda_low)) else $error("sda oe");
	a_sda_only_low: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
	a_input_sync: assert property (s_steady |-> core_input_pins == input_pins) else $error("input sync");
endmodule
bind bsc_test_port bsc_sva chk (.*);
`default_nettype wire

// >>> tb/bsc_tester.sv
// Board tester model at the test access port
`default_nettype none
module bsc_tester (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n,
	input  wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Test clock runs only inside a frame
	// ----
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
	end
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#23;
		q = tdo;
		tck = 1'b1;
		#25;
		tck = 1'b0;
	endtask
	task automatic reset_tap();
		logic q;
		trst_n = 1'b0;
		#30;
		trst_n = 1'b1;
		#48;
		step(1'b0, 1'b0, q);
	endtask
	task automatic scan(input logic ir, input int n, input logic [79:0] din, output logic [79:0] dout);
		logic q;
		dout = '0;
		step(1'b1, ~din[0], q);
		if (ir) step(1'b1, ~din[0], q);
		step(1'b0, ~din[0], q);
		step(1'b0, ~din[0], q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~din[n - 1], q);
		step(1'b0, din[n - 1], q);
	endtask
endmodule
`default_nettype wire

// >>> tb/boundary_scan_test_port_bench.sv
// Self-checking bench of the boundary scan test port
`default_nettype none
module boundary_scan_test_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, reset_n, tck, tms, tdi, trst_n, tdo, tdo_oe, core_flags_oe, flag_pins_oe, sda_ext, o;
	logic        core_port_a_oe, pixel_port_a_oe, core_sda_low, sda_in, sda_out, sda_oe, core_sda_in, extest_active;
	logic [7:0]  core_flags, flag_pins, core_port_a_out, pixel_port_a_in, pixel_port_a_out, core_port_a_in, pa_ext;
	logic [5:0]  input_pins, core_input_pins;
	logic [8:0]  core_analog_ctrl, analog_ctrl;
	logic [14:0] adc_data, core_adc_data;
	logic [21:0] misc_observe, misc_drive;
	logic [79:0] v, d;
	logic [3:0]  codes [3] = '{bsc_pkg::IR_BYPASS, 4'h7, 4'hc};
	int          failures, checked, cyc;
	bsc_test_port dut (.*);
	bsc_tester tap (.*);
	// Wire levels from both parties' drive; data pin pulled up
	assign pixel_port_a_in = pixel_port_a_oe ? pixel_port_a_out : pa_ext;
	assign sda_in = ~(sda_oe | sda_ext);
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			give_verdict();
		end
	end
	// ----
	// Helpers
	// ----
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic rnd();
		if (reset_n) @(negedge sys_clk);
		{core_flags, core_flags_oe, input_pins, core_port_a_out, core_port_a_oe} = 24'($urandom);
		{pa_ext, core_sda_low, sda_ext} = 10'($urandom);
		{core_analog_ctrl, adc_data, misc_observe} = 46'({$urandom, $urandom});
		repeat (reset_n ? 12 : 6) @(negedge sys_clk);
	endtask
	function automatic logic [79:0] cap();
		logic [79:0] e;
		e = {misc_observe[21:19], 16'h0, misc_observe[18], sda_in, ~core_sda_low, misc_observe[17:0], 14'h0,
			core_flags_oe, adc_data, core_analog_ctrl[8:1], ~core_port_a_oe, core_analog_ctrl[0]};
		for (int i = 0; i < 8; i++) begin
			e[bsc_pkg::FLAG_POS[i]] = core_flags[i];
			e[61 + 2 * i] = core_port_a_out[i];
			e[62 + 2 * i] = pixel_port_a_in[i];
		end
		for (int i = 0; i < 6; i++) e[bsc_pkg::INPUT_POS[i]] = input_pins[i];
		return e;
	endfunction
	task automatic ld(input logic [3:0] c);
		tap.scan(1'b1, 4, 80'(c), d);
		chk(80'(d[3:0]), 80'(bsc_pkg::IR_CAPTURE)); // capture pattern
	endtask
	task automatic idchk();
		tap.scan(1'b0, 32, v, d);
		chk(80'(d[31:0]), 80'({bsc_pkg::ID_VERSION, bsc_pkg::ID_PART, bsc_pkg::ID_MANUF, 1'b1})); // id word
	endtask
	task automatic drive_chk();
		logic [7:0] f, a;
		for (int i = 0; i < 8; i++) begin
			f[i] = v[bsc_pkg::FLAG_POS[i]];
			a[i] = v[61 + 2 * i];
		end
		repeat (8) @(negedge sys_clk);
		chk(80'({extest_active, flag_pins_oe, pixel_port_a_oe, sda_oe, flag_pins, pixel_port_a_out, analog_ctrl,
			misc_drive, core_adc_data, core_sda_in, core_port_a_in}),
			80'({1'b1, v[25], ~v[1], ~v[58], f, a, v[9:2], v[0], v[79:77], v[60], v[57:40], v[24:10],
			~(~v[58] | sda_ext), (~v[1] ? a : pa_ext)}));
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		void'($urandom(54));
		rnd();
		reset_n = 1'b1;
		tap.reset_tap();
		v = 80'({$urandom, $urandom, $urandom});
		idchk(); // id after test reset
		foreach (codes[k]) begin
			ld(codes[k]);
			tap.scan(1'b0, 8, v, d);
			chk(80'(d[7:0]), 80'({v[6:0], 1'b0})); // one bit path
		end
		ld(bsc_pkg::IR_SAMPLE);
		rnd();
		v[1] = 1'b0;
		v[25] = 1'b1;
		v[58] = 1'b0;
		tap.scan(1'b0, 80, v, d);
		chk(d, cap()); // captured levels
		ld(bsc_pkg::IR_EXTEST);
		drive_chk(); // preload applied
		v = ~v;
		tap.scan(1'b0, 80, v, d);
		drive_chk(); // drivers released
		tap.step(1'b1, 1'b0, o);
		tap.step(1'b0, 1'b0, o);
		tap.step(1'b0, 1'b1, o);
		tap.reset_tap();
		repeat (8) @(negedge sys_clk);
		chk(80'({extest_active, flag_pins_oe, pixel_port_a_oe, sda_oe}),
			80'({1'b0, core_flags_oe, core_port_a_oe, core_sda_low})); // mode dropped
		idchk(); // id reloaded
		ld(bsc_pkg::IR_BYPASS);
		repeat (5) tap.step(1'b1, 1'b0, o);
		tap.step(1'b0, 1'b0, o);
		idchk(); // tms reset path
		give_verdict();
	end
endmodule
`default_nettype wire
